// ==== common/wdg_pkg.sv ====
package wdg_pkg;
  // register map
  localparam logic [7:0] KEY_ADDR  = 8'ha6;
  localparam logic [7:0] CTRL_ADDR = 8'ha7;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // control field positions
  localparam int PS_HI  = 7;
  localparam int PS_LO  = 5;
  localparam int IDLE_B = 4;
  localparam int ROD_B  = 3;
  localparam int HWM_B  = 2;
  localparam int SR_B   = 1;
  localparam int EN_B   = 0;
  // restart key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h1e;
  localparam logic [7:0] KEY_SECOND = 8'he1;
  // shortest period is 2**14 = 16K machine cycles
  localparam int BASE_LOG2_DEF = 14;
  localparam int PS_STEPS      = 7;
  // oscillator periods per machine cycle
  localparam int MC_DIV_DEF    = 12;
  // internal reset pulse length in machine cycles
  localparam int PULSE_MC_DEF  = 2;

  typedef enum logic {
    KEY_IDLE = 1'b0,
    KEY_HALF = 1'b1
  } wdg_key_st_t;
endpackage : wdg_pkg

// ==== logic/wdg_key_det.sv ====
`timescale 1ns/10ps
`default_nettype none
module wdg_key_det (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  output logic            key_ok
);
  import wdg_pkg::*;

  wdg_key_st_t st_ff;

  // only back-to-back writes to the key register form a key
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= KEY_IDLE;
    end else if (key_wr) begin
      unique case (st_ff)
        KEY_IDLE: begin
          st_ff <= (key_data == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
        KEY_HALF: begin
          // a stray byte drops the half key; 1e starts over
          st_ff <= (key_data == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      key_ok <= 1'b0;
    end else begin
      key_ok <= key_wr && st_ff == KEY_HALF && key_data == KEY_SECOND;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_key_pair: assert property (
    key_ok |-> $past(key_wr) && $past(key_data) == KEY_SECOND
      && $past(st_ff) == KEY_HALF)
    else $error("key accepted without a preceding first byte");
  chk_key_drop: assert property (
    key_wr && key_data != KEY_FIRST && key_data != KEY_SECOND
      |=> st_ff == KEY_IDLE ##1 !key_ok)
    else $error("stray byte did not discard the partial key");
endmodule : wdg_key_det
`default_nettype wire

// ==== logic/wdg_mc_div.sv ====
`timescale 1ns/10ps
`default_nettype none
module wdg_mc_div #(
  parameter int unsigned DIV = wdg_pkg::MC_DIV_DEF
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  import wdg_pkg::*;

  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_ff == LAST);
    end
  end
endmodule : wdg_mc_div
`default_nettype wire

// ==== logic/wdg_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - counter steps once per machine cycle; off after reset, halted in power-down.
// - reaching the selected period unserviced emits an internal cpu reset pulse.
// - period select 000 gives 16K cycles, each code doubles, 111 gives 2048K.
// - idle freeze 0 keeps counting in idle; 1 holds the count while idle.
// - reset-out disable 0 makes a timeout also drive the reset pin high.
// - reset-out disable 1 leaves the pin an input; timeout resets chip only.
// - software mode: soft enable bit directly starts and stops the watchdog.
// - hardware mode: writing 1e then e1 to the key register starts it.
// - once started in hardware mode nothing but a reset stops it.
// - hardware mode: the same key before each timeout restarts the count.
// - software mode: soft restart 1 restarts; hardware clears it next cycle.
// - hardware mode: soft restart has no effect and stays set.
// - software mode: clearing soft enable freezes the count without clearing.
// - hardware mode: soft enable is read-only and shows the running state.
// - control register at a7, reset zero, fields ps, idle, rod, hw, sr, en.
module wdg_top #(
  parameter int unsigned BASE_LOG2 = wdg_pkg::BASE_LOG2_DEF,
  parameter int unsigned MC_DIV    = wdg_pkg::MC_DIV_DEF,
  parameter int unsigned PULSE_MC  = wdg_pkg::PULSE_MC_DEF
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic       IDLE,
  input  wire logic       POWER_DOWN,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            CPU_RST,
  output logic            RST_PIN_OUT,
  output logic            RST_PIN_OE,
  output logic            WDG_RUN
);
  import wdg_pkg::*;

  localparam int CNT_W = BASE_LOG2 + PS_STEPS;
  localparam int PW    = $clog2(PULSE_MC + 1);
  localparam int SR_WAIT = 2 * MC_DIV;
  localparam int PULSE_CYC = PULSE_MC * MC_DIV;

  logic [2:0]       ps_ff;
  logic             idle_frz_ff;
  logic             rod_ff;
  logic             hwm_ff;
  logic             sr_ff;
  logic             en_ff;
  logic             hw_run_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [PW-1:0]    pulse_ff;
  logic             drive_ff;

  logic             mc_tick;
  logic             key_ok;
  logic             ctrl_wr;
  logic             key_wr;
  logic             running;
  logic             advance;
  logic             timeout;
  logic             sw_restart;
  logic             hw_restart;
  logic [CNT_W-1:0] last_cnt;
  logic [7:0]       ctrl_view;

  assign ctrl_wr = REG_WR && REG_ADDR == CTRL_ADDR;
  assign key_wr  = REG_WR && REG_ADDR == KEY_ADDR;

  wdg_mc_div #(
    .DIV (MC_DIV)
  ) u_div (
    .clk  (REF_CLK),
    .rst  (RST),
    .tick (mc_tick)
  );

  wdg_key_det u_key (
    .clk      (REF_CLK),
    .rst      (RST),
    .key_wr   (key_wr),
    .key_data (REG_WDATA),
    .key_ok   (key_ok)
  );

  assign running    = hwm_ff ? hw_run_ff : en_ff;
  // power-down and idle freeze gate the machine-cycle step
  assign advance    = running && mc_tick && !POWER_DOWN
                      && !(IDLE && idle_frz_ff);
  // all-ones of the selected period width: 2**(BASE_LOG2+ps) - 1
  assign last_cnt   = {CNT_W{1'b1}} >> (3'(PS_STEPS) - ps_ff);
  assign timeout    = advance && cnt_ff == last_cnt;
  assign sw_restart = ctrl_wr && !hwm_ff && REG_WDATA[SR_B];
  assign hw_restart = key_ok && hwm_ff;

  assign ctrl_view = {ps_ff, idle_frz_ff, rod_ff, hwm_ff, sr_ff,
                      hwm_ff ? hw_run_ff : en_ff};

  // a timeout acts as a warm reset of the watchdog itself
  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      ps_ff       <= CTRL_RST[PS_HI:PS_LO];
      idle_frz_ff <= CTRL_RST[IDLE_B];
      rod_ff      <= CTRL_RST[ROD_B];
    end else if (ctrl_wr) begin
      ps_ff       <= REG_WDATA[PS_HI:PS_LO];
      idle_frz_ff <= REG_WDATA[IDLE_B];
      rod_ff      <= REG_WDATA[ROD_B];
    end
  end

  // mode cannot be left once the hardware watchdog runs
  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      hwm_ff <= CTRL_RST[HWM_B];
    end else if (ctrl_wr && !hw_run_ff) begin
      hwm_ff <= REG_WDATA[HWM_B];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      en_ff <= CTRL_RST[EN_B];
    end else if (ctrl_wr && !hwm_ff) begin
      en_ff <= REG_WDATA[EN_B];
    end
  end

  // the write wins over the hardware clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      sr_ff <= CTRL_RST[SR_B];
    end else if (ctrl_wr && REG_WDATA[SR_B]) begin
      sr_ff <= 1'b1;
    end else if (ctrl_wr) begin
      sr_ff <= 1'b0;
    end else if (sr_ff && !hwm_ff && mc_tick) begin
      sr_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      hw_run_ff <= 1'b0;
    end else if (hw_restart) begin
      hw_run_ff <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || timeout) begin
      cnt_ff <= '0;
    end else if (sw_restart || hw_restart) begin
      cnt_ff <= '0;
    end else if (advance) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
    // a disabled counter holds, but a soft restart write still clears it here
  end

  // reset pulse, timed in machine cycles
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pulse_ff <= '0;
    end else if (timeout) begin
      pulse_ff <= PW'(PULSE_MC);
    end else if (pulse_ff != '0 && mc_tick) begin
      pulse_ff <= pulse_ff - 1'b1;
    end
  end

  // pin drive choice is latched at the timeout, as the control clears
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      drive_ff <= 1'b0;
    end else if (timeout) begin
      drive_ff <= !rod_ff;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CPU_RST <= 1'b0;
    end else begin
      CPU_RST <= timeout || (pulse_ff > PW'(1))
                 || (pulse_ff == PW'(1) && !mc_tick);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RST_PIN_OUT <= 1'b0;
      RST_PIN_OE  <= 1'b0;
    end else begin
      RST_PIN_OUT <= (timeout && !rod_ff)
                     || (drive_ff && CPU_RST && pulse_ff != '0);
      RST_PIN_OE  <= (timeout && !rod_ff)
                     || (drive_ff && CPU_RST && pulse_ff != '0);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      WDG_RUN <= 1'b0;
    end else begin
      WDG_RUN <= running && !timeout;
    end
  end

  // the key register is write-only and reads as zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= (REG_ADDR == CTRL_ADDR) ? ctrl_view : 8'h00;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_pd_hold: assert property (
    POWER_DOWN && !sw_restart && !hw_restart |=> $stable(cnt_ff))
    else $error("counter moved in power-down");

  chk_reset_off: assert property (
    $past(RST) |-> !running && cnt_ff == '0)
    else $error("watchdog active right after reset");

  chk_timeout_pulse: assert property (
    timeout |=> CPU_RST && cnt_ff == '0 && !WDG_RUN)
    else $error("timeout without an internal reset pulse");

  chk_pulse_len: assert property (
    timeout |-> ##PULSE_CYC CPU_RST ##1 !CPU_RST)
    else $error("internal reset pulse has the wrong length");

  chk_period_len: assert property (
    timeout |-> 32'(cnt_ff) + 1 == (32'd1 << (BASE_LOG2 + 32'(ps_ff))))
    else $error("timeout not at the selected period");

  chk_idle_freeze: assert property (
    IDLE && idle_frz_ff && !sw_restart && !hw_restart
      |=> $stable(cnt_ff))
    else $error("counter moved while idle with freeze set");

  chk_idle_count: assert property (
    IDLE && !idle_frz_ff && running && mc_tick && !POWER_DOWN
      && !timeout && !sw_restart && !hw_restart
      |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("counter stalled in idle without freeze");

  chk_pin_drive: assert property (
    timeout && !rod_ff |=> RST_PIN_OE && RST_PIN_OUT ##1 RST_PIN_OE)
    else $error("reset pin not driven on timeout");

  chk_pin_input: assert property (
    timeout && rod_ff |=> !RST_PIN_OE [*3])
    else $error("reset pin driven while reset-out disabled");

  chk_sw_enable: assert property (
    ctrl_wr && !hwm_ff && !timeout |=> en_ff == $past(REG_WDATA[EN_B]))
    else $error("soft enable write not applied");

  chk_key_start: assert property (
    key_ok && hwm_ff && !timeout |=> hw_run_ff ##1 WDG_RUN)
    else $error("complete key did not start hardware watchdog");

  chk_key_inert: assert property (
    key_ok && !hwm_ff && !hw_run_ff |=> !hw_run_ff)
    else $error("key started the watchdog in software mode");

  chk_hw_sticky: assert property (
    hw_run_ff && !timeout |=> hw_run_ff && hwm_ff)
    else $error("hardware watchdog stopped without reset");

  chk_key_restart: assert property (
    hw_restart && !timeout |=> cnt_ff == '0)
    else $error("complete key did not restart the count");

  chk_sr_clear: assert property (
    sw_restart && !timeout
      |=> cnt_ff == '0 && sr_ff ##[1:SR_WAIT] !sr_ff)
    else $error("soft restart not cleared by hardware");

  chk_sr_hw_stay: assert property (
    hwm_ff && sr_ff && !ctrl_wr && !timeout |=> sr_ff)
    else $error("soft restart cleared in hardware mode");

  chk_sr_no_effect: assert property (
    hwm_ff && ctrl_wr && REG_WDATA[SR_B] && !hw_restart && !timeout
      |=> cnt_ff == $past(cnt_ff) + CNT_W'($past(advance)))
    else $error("soft restart moved the counter in hardware mode");

  chk_sw_stop: assert property (
    !hwm_ff && !en_ff && !sw_restart |=> $stable(cnt_ff))
    else $error("disabled counter changed");

  chk_en_readonly: assert property (
    hwm_ff && REG_ADDR == CTRL_ADDR |=> REG_RDATA[EN_B] == $past(hw_run_ff))
    else $error("soft enable does not show running state");

  chk_ctrl_reset: assert property (
    $past(RST) |-> ctrl_view == CTRL_RST)
    else $error("control register not zero after reset");

  cov_sw_timeout: cover property (!hwm_ff && timeout);
  cov_hw_timeout: cover property (hw_run_ff && timeout && !rod_ff);
  cov_key_service: cover property (hw_run_ff && hw_restart);
  cov_idle_hold: cover property (IDLE && idle_frz_ff && running);
  cov_rod_timeout: cover property (timeout && rod_ff);
endmodule : wdg_top
`default_nettype wire

// ==== verif/prog_watchdog_timer_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module prog_watchdog_timer_bench;
  import wdg_pkg::*;
  localparam int BL = 2;
  localparam int MD = 2;
  logic       clk, rst, idle, pd, wr, cpu_rst, pin_out, pin_oe, run;
  logic [7:0] addr, wdata, rdata;
  int         fails, comparisons, cyc;

  wdg_top #(.BASE_LOG2(BL), .MC_DIV(MD), .PULSE_MC(2)) u_wdg_top (
    .REF_CLK(clk), .RST(rst), .IDLE(idle), .POWER_DOWN(pd),
    .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .CPU_RST(cpu_rst), .RST_PIN_OUT(pin_out), .RST_PIN_OE(pin_oe),
    .WDG_RUN(run));
  wdg_cpu_model u_wdg_cpu_model (
    .clk(clk), .wr(wr), .addr(addr), .wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // whole run needs about 2500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_wdg_cpu_model.put(a, d);
  endtask : w

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_wdg_cpu_model.sel(a);
    #1;
    chk(rdata, e);
  endtask : rdc

  task automatic wait_rst(input int lim, output int n);
    n = 0;
    while (cpu_rst !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_rst

  // window is loose by a tick: the prescaler phase is not visible
  task automatic to_chk(input int lo, input int hi, input logic rod);
    int n;
    wait_rst(hi + 4, n);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
    chk({6'h00, pin_oe, pin_out}, rod ? 8'h00 : 8'h03);
    repeat (8) @(posedge clk);
  endtask : to_chk

  task automatic t_reset();
    rdc(CTRL_ADDR, CTRL_RST);
    rdc(8'h5a, 8'h00);
    chk({5'h00, cpu_rst, pin_oe, run}, 8'h00);
    $display("reset values done");
  endtask : t_reset

  task automatic t_period();
    for (int ps = 0; ps < 8; ps++) begin
      w(CTRL_ADDR, {3'(ps), 5'h03});
      to_chk((2**(BL+ps))*MD-2, (2**(BL+ps))*MD+MD+2, 1'b0);
      rdc(CTRL_ADDR, CTRL_RST);
    end
    w(CTRL_ADDR, 8'h09);
    to_chk(6, 12, 1'b1);
    $display("periods done");
  endtask : t_period

  task automatic t_freeze();
    int n;
    w(CTRL_ADDR, 8'h01);
    repeat (3) @(posedge clk);
    w(CTRL_ADDR, 8'h00);
    u_wdg_cpu_model.key();
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, run}, 8'h00);
    wait_rst(40, n);
    chk(8'(n), 8'h28);
    w(CTRL_ADDR, 8'h01);
    wait_rst(20, n);
    chk({7'h00, n < 5}, 8'h01);
    repeat (8) @(posedge clk);
    $display("freeze done");
  endtask : t_freeze

  task automatic t_idle();
    int n;
    @(posedge clk);
    idle <= 1'b1;
    w(CTRL_ADDR, 8'h11);
    wait_rst(40, n);
    chk(8'(n), 8'h28);
    @(posedge clk);
    idle <= 1'b0;
    to_chk(0, 12, 1'b0);
    pd <= 1'b1;
    w(CTRL_ADDR, 8'h01);
    wait_rst(40, n);
    chk(8'(n), 8'h28);
    @(posedge clk);
    pd <= 1'b0;
    to_chk(0, 12, 1'b0);
    idle <= 1'b1;
    w(CTRL_ADDR, 8'h01);
    to_chk(6, 12, 1'b0);
    idle <= 1'b0;
    $display("idle done");
  endtask : t_idle

  task automatic t_soft();
    w(CTRL_ADDR, 8'h01);
    repeat (4) begin
      w(CTRL_ADDR, 8'h03);
      rdc(CTRL_ADDR, 8'h01);
    end
    w(CTRL_ADDR, 8'h03);
    to_chk(6, 12, 1'b0);
    $display("soft restart done");
  endtask : t_soft

  task automatic t_hw();
    w(CTRL_ADDR, 8'he4);
    w(KEY_ADDR, KEY_FIRST);
    w(KEY_ADDR, 8'h55);
    w(KEY_ADDR, KEY_SECOND);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, run}, 8'h00);
    u_wdg_cpu_model.key();
    repeat (2) @(posedge clk);
    rdc(CTRL_ADDR, 8'he5);
    w(CTRL_ADDR, 8'he2);
    rdc(CTRL_ADDR, 8'he7);
    u_wdg_cpu_model.key();
    w(CTRL_ADDR, 8'h06);
    repeat (5) begin
      u_wdg_cpu_model.key();
      @(posedge clk);
    end
    #1;
    chk({6'h00, cpu_rst, run}, 8'h01);
    to_chk(4, 14, 1'b0);
    rdc(CTRL_ADDR, CTRL_RST);
    $display("hardware mode done");
  endtask : t_hw

  initial begin
    rst         = 1'b1;
    idle        = 1'b0;
    pd          = 1'b0;
    fails       = 0;
    comparisons = 0;
    cyc         = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_freeze();
    t_idle();
    t_soft();
    t_hw();
    stop_test();
  end
endmodule : prog_watchdog_timer_bench
`default_nettype wire

// ==== verif/wdg_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module wdg_cpu_model
  import wdg_pkg::*;
(
  input  wire logic       clk,
  output logic            wr,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  initial begin
    wr    = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // one byte per call; data is scrambled once the strobe is gone
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : put

  task automatic key();
    put(KEY_ADDR, KEY_FIRST);
    put(KEY_ADDR, KEY_SECOND);
  endtask : key

  // read data follows the address one edge later; sel waits two edges
  task automatic sel(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
  endtask : sel
endmodule : wdg_cpu_model
`default_nettype wire
